//--- include/ltls_regs.vh
// Constants for the lookup table and logic selector block.
// Assumes a word-indexed register port and a 50 MHz system clock.
`ifndef LTLS_REGS_VH
`define LTLS_REGS_VH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define LTLS_NTBL        6
`define LTLS_NPT         11
`define LTLS_NSEL        2
`define LTLS_NCAND       3
`define LTLS_NCND        18
`define LTLS_NPOOL       16
`define LTLS_NCONST      8
`define LTLS_LAST_TBL    3'h5
`define LTLS_DIV_STEPS   6'h31

// ----------------------------------------------------------------
// Address map (word index on reg_addr)
// ----------------------------------------------------------------
`define LTLS_A_REGION    9:8
`define LTLS_A_TBL       8:6
`define LTLS_A_KIND      5:4
`define LTLS_A_PT        3:0
`define LTLS_A_SEL       6
`define LTLS_A_FIELD     5:0
`define LTLS_A_CONST     2:0
`define LTLS_R_TBL_LO    2'h0
`define LTLS_R_TBL_HI    2'h1
`define LTLS_R_SEL       2'h2
`define LTLS_R_CONST     2'h3
`define LTLS_K_PR        2'h0
`define LTLS_K_X         2'h1
`define LTLS_K_Y         2'h2
`define LTLS_K_ST        2'h3
`define LTLS_ST_OUT      4'h0
`define LTLS_ST_DEC      4'h1
`define LTLS_ST_MS       4'h2
`define LTLS_S_EN        6'h00
`define LTLS_S_TBL       6'h01
`define LTLS_S_CMB       6'h04
`define LTLS_S_CND       6'h10
`define LTLS_S_CND_END   6'h21
`define LTLS_S_ACT       6'h30
`define LTLS_S_OUT       6'h31

// ----------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------
`define LTLS_AX_DATA     8'h00
`define LTLS_AX_TIME     8'h01
`define LTLS_PT_IGNORE   8'h00
`define LTLS_PT_RAMP     8'h01
`define LTLS_PT_STEP     8'h02
`define LTLS_DEF_STEP    10
`define LTLS_OP_EQ       3'h0
`define LTLS_OP_NE       3'h1
`define LTLS_OP_GT       3'h2
`define LTLS_OP_GE       3'h3
`define LTLS_OP_LT       3'h4
`define LTLS_OP_LE       3'h5
`define LTLS_RS_FALSE    2'h0
`define LTLS_RS_TRUE     2'h1
`define LTLS_RS_ERR      2'h2
`define LTLS_RS_NA       2'h3
`define LTLS_CB_DEFAULT  3'h0
`define LTLS_CB_ALL      3'h1
`define LTLS_CB_ANY      3'h2
`define LTLS_CB_AB_OR_C  3'h3
`define LTLS_CB_AORB_C   3'h4
`define LTLS_SRC_NONE    8'h00
`define LTLS_SRC_POOL    8'h01
`define LTLS_SRC_CONST   8'h02

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LTLS_MS_NS       1000000
`define LTLS_CLK_NS      20
`define LTLS_T_MIN_MS    32'h00000001
`define LTLS_T_MAX_MS    32'h05265C00

`endif

//--- rtl/ltls_div.v
// Serial restoring divider used for ramp interpolation.
// Assumes start is a one-cycle pulse given only while idle.
`timescale 1ns/10ps
`include "ltls_regs.vh"

module ltls_div (
  input  wire        clk,       // System clock.
  input  wire        sys_rst,   // Synchronous reset, active high.
  input  wire        start,     // Pulse: load operands and begin.
  input  wire [48:0] dividend,  // Unsigned dividend.
  input  wire [31:0] divisor,   // Unsigned divisor, never zero.
  output reg         done,      // Pulse: quotient is valid.
  output reg  [48:0] quotient   // Result, held until next start.
);

  reg  [31:0] rem;
  reg  [31:0] dvs;
  reg  [5:0]  cnt;
  reg         busy;
  wire [32:0] shifted = {rem, quotient[48]};
  wire        fits    = (shifted >= {1'b0, dvs});
  wire [32:0] diff    = shifted - {1'b0, dvs};

  // ----------------------------------------------------------------
  // One quotient bit per clock
  // ----------------------------------------------------------------
  // A serial divider costs 49 cycles, far below one millisecond tick.
  always @(posedge clk) begin
    done <= 1'b0;
    if (sys_rst) begin
      rem      <= 32'h00000000;
      dvs      <= 32'h00000000;
      cnt      <= 6'h00;
      busy     <= 1'b0;
      quotient <= 49'h0000000000000;
    end else if (start) begin
      rem      <= 32'h00000000;
      dvs      <= divisor;
      cnt      <= `LTLS_DIV_STEPS;
      busy     <= 1'b1;
      quotient <= dividend;
    end else if (busy) begin
      rem      <= fits ? diff[31:0] : shifted[31:0];
      quotient <= {quotient[47:0], fits};
      cnt      <= cnt - 6'h01;
      if (cnt == 6'h01) begin
        busy <= 1'b0;
        done <= 1'b1;
      end
    end
  end

endmodule // ltls_div

//--- rtl/ltls_top.v
// Six piecewise lookup tables and two logic selectors.
// Assumes synchronous inputs from other function blocks and a
// word-indexed register port with one-cycle strobes.
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "ltls_regs.vh"

module ltls_top #(
  parameter MS_CYCLES = `LTLS_MS_NS / `LTLS_CLK_NS  // Clocks per ms.
) (
  input  wire         clk,              // System clock, 50 MHz.
  input  wire         sys_rst,          // Synchronous reset, high.
  input  wire [9:0]   reg_addr,         // Register word index.
  input  wire [31:0]  reg_wdata,        // Register write data.
  input  wire         reg_wr,           // Write strobe.
  input  wire         reg_rd,           // Read strobe.
  output reg  [31:0]  reg_rdata,        // Read data, next cycle.
  input  wire [95:0]  tbl_in_value,     // Data input per table.
  input  wire [5:0]   tbl_in_on,        // Control on, time mode.
  input  wire [255:0] pool_value,       // Block outputs, signed.
  input  wire [15:0]  pool_error,       // Block output in error.
  input  wire [15:0]  pool_avail,       // Block output available.
  output reg  [95:0]  tbl_out_value,    // Table outputs, signed.
  output reg  [31:0]  sel_out_value,    // Selector outputs.
  output reg  [5:0]   sel_active_table, // Selected table number.
  output reg  [1:0]   sel_out_avail     // Selector output valid.
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // point_response_array, input_coordinate_array and outputs.
  reg  [7:0]  pr   [0:65];
  reg  [31:0] xc   [0:65];
  reg  [15:0] yc   [0:65];
  reg  [7:0]  dec  [0:5];
  reg  [31:0] ms_cnt [0:5];
  reg  [31:0] cnd  [0:17];  // {num2, src2, num1, src1}.
  reg  [2:0]  cop  [0:17];
  reg  [2:0]  ctn  [0:5];   // candidate_table_number.
  reg  [2:0]  cmb  [0:5];   // candidate_combine_operator.
  reg  [15:0] kval [0:7];   // constant_value_set.
  reg  [1:0]  sel_en;       // selector_enable_flags.
  reg  [15:0] tick_cnt;
  reg         ms_tick;
  integer     i;
  integer     s;
  integer     c;
  integer     j;
  integer     sn;
  integer     cn;

  // Flat index of point p of table t.
  function [6:0] pidx;
    input [2:0] t;
    input [3:0] p;
    begin
      pidx = t * 7'd11 + {3'h0, p};
    end
  endfunction

  // Identity profile value for flat entry i.
  function [15:0] dflt;
    input integer n;
    integer v;
    begin
      v    = (n % `LTLS_NPT) * `LTLS_DEF_STEP;
      dflt = v[15:0];
    end
  endfunction

  // Fetch an argument: {status, value}.
  function [17:0] arg_fetch;
    input [7:0] src;
    input [7:0] num;
    begin
      arg_fetch = {`LTLS_RS_NA, 16'h0000};
      if (src == `LTLS_SRC_POOL && num < `LTLS_NPOOL) begin
        if (!pool_avail[num[3:0]])
          arg_fetch = {`LTLS_RS_NA, 16'h0000};
        else if (pool_error[num[3:0]])
          arg_fetch = {`LTLS_RS_ERR, 16'h0000};
        else
          arg_fetch = {`LTLS_RS_TRUE, pool_value[num[3:0]*16 +: 16]};
      end else if (src == `LTLS_SRC_CONST && num < `LTLS_NCONST) begin
        arg_fetch = {`LTLS_RS_TRUE, kval[num[2:0]]};
      end
    end
  endfunction

  // Evaluate one condition into a 2-bit result.
  function [1:0] cond_eval;
    input [31:0] w;
    input [2:0]  op;
    reg   [17:0] a1;
    reg   [17:0] a2;
    reg   signed [15:0] v1;
    reg   signed [15:0] v2;
    begin
      a1 = arg_fetch(w[7:0], w[15:8]);
      a2 = arg_fetch(w[23:16], w[31:24]);
      v1 = a1[15:0];
      v2 = a2[15:0];
      if (a1[17:16] == `LTLS_RS_NA || a2[17:16] == `LTLS_RS_NA)
        cond_eval = `LTLS_RS_NA;
      else if (a1[17:16] == `LTLS_RS_ERR || a2[17:16] == `LTLS_RS_ERR)
        cond_eval = `LTLS_RS_ERR;
      else begin
        case (op)
          `LTLS_OP_EQ: cond_eval = {1'b0, v1 == v2};
          `LTLS_OP_NE: cond_eval = {1'b0, v1 != v2};
          `LTLS_OP_GT: cond_eval = {1'b0, v1 > v2};
          `LTLS_OP_GE: cond_eval = {1'b0, v1 >= v2};
          `LTLS_OP_LT: cond_eval = {1'b0, v1 < v2};
          `LTLS_OP_LE: cond_eval = {1'b0, v1 <= v2};
          default:     cond_eval = `LTLS_RS_FALSE;
        endcase
      end
    end
  endfunction

  // Combine three results under a candidate operator.
  function cmb_met;
    input [1:0] r1;
    input [1:0] r2;
    input [1:0] r3;
    input [2:0] op;
    reg t1, t2, t3, n1, n2, n3;
    begin
      t1 = (r1 == `LTLS_RS_TRUE);
      t2 = (r2 == `LTLS_RS_TRUE);
      t3 = (r3 == `LTLS_RS_TRUE);
      n1 = t1 | (r1 == `LTLS_RS_NA);
      n2 = t2 | (r2 == `LTLS_RS_NA);
      n3 = t3 | (r3 == `LTLS_RS_NA);
      case (op)
        `LTLS_CB_DEFAULT: cmb_met = 1'b1;
        `LTLS_CB_ALL:     cmb_met = n1 & n2 & n3;
        `LTLS_CB_ANY:     cmb_met = t1 | t2 | t3;
        `LTLS_CB_AB_OR_C: cmb_met = (t1 & t2) | t3;
        `LTLS_CB_AORB_C:  cmb_met = (t1 | t2) & t3;
        default:          cmb_met = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire [1:0] a_reg  = reg_addr[`LTLS_A_REGION];
  wire [2:0] a_tbl  = reg_addr[`LTLS_A_TBL];
  wire [1:0] a_kind = reg_addr[`LTLS_A_KIND];
  wire [3:0] a_pt   = reg_addr[`LTLS_A_PT];
  wire       a_sel  = reg_addr[`LTLS_A_SEL];
  wire [5:0] a_fld  = reg_addr[`LTLS_A_FIELD];
  wire       in_tbl = (a_reg == `LTLS_R_TBL_LO || a_reg == `LTLS_R_TBL_HI)
                      && a_tbl <= `LTLS_LAST_TBL && a_pt < `LTLS_NPT;
  wire [6:0] a_ix   = pidx(a_tbl, a_pt);
  wire       a_time = (pr[pidx(a_tbl, 4'h0)] == `LTLS_AX_TIME);
  wire [5:0] f_cnd  = a_fld - `LTLS_S_CND;
  wire [4:0] c_ix   = {4'h0, a_sel} * 5'd9 + {1'b0, f_cnd[4:1]};
  wire [2:0] s_ix   = {2'h0, a_sel} * 3'd3 + a_fld[2:0] - 3'h1;
  wire [2:0] m_ix   = {2'h0, a_sel} * 3'd3 + a_fld[2:0] - 3'h4;

  // Writes; read-only and unmapped words ignore them.
  always @(posedge clk) begin
    if (sys_rst) begin
      for (i = 0; i < 66; i = i + 1) begin
        pr[i] <= (dflt(i) == 16'h0000) ? `LTLS_AX_DATA : `LTLS_PT_RAMP;
        xc[i] <= {16'h0000, dflt(i)};
        yc[i] <= dflt(i);
      end
      for (i = 0; i < `LTLS_NTBL; i = i + 1) begin
        dec[i] <= 8'h00;
        ctn[i] <= i[2:0] + 3'h1;
        cmb[i] <= (i % 3 == 2) ? `LTLS_CB_DEFAULT : `LTLS_CB_ALL;
      end
      for (i = 0; i < `LTLS_NCND; i = i + 1) begin
        cnd[i] <= {8'h00, `LTLS_SRC_NONE, 8'h00, `LTLS_SRC_NONE};
        cop[i] <= `LTLS_OP_EQ;
      end
      for (i = 0; i < `LTLS_NCONST; i = i + 1)
        kval[i] <= 16'h0000;
      sel_en <= 2'h0;
    end else begin
      if (reg_wr && in_tbl) begin
        if (a_kind == `LTLS_K_PR) begin
          if (a_pt == 4'h0) begin
            if (reg_wdata[7:0] <= `LTLS_AX_TIME)
              pr[a_ix] <= reg_wdata[7:0];
          end else if (reg_wdata[7:0] <= `LTLS_PT_STEP)
            pr[a_ix] <= reg_wdata[7:0];
        end else if (a_kind == `LTLS_K_X) begin
          if (!a_time)
            xc[a_ix] <= reg_wdata;
          else if (a_pt != 4'h0 && reg_wdata < `LTLS_T_MIN_MS)
            xc[a_ix] <= `LTLS_T_MIN_MS;
          else if (a_pt != 4'h0 && reg_wdata > `LTLS_T_MAX_MS)
            xc[a_ix] <= `LTLS_T_MAX_MS;
          else if (a_pt != 4'h0)
            xc[a_ix] <= reg_wdata;
        end else if (a_kind == `LTLS_K_Y) begin
          if (!a_time || a_pt != 4'h0)
            yc[a_ix] <= reg_wdata[15:0];
        end else if (a_pt == `LTLS_ST_DEC)
          dec[a_tbl] <= reg_wdata[7:0];
      end else if (reg_wr && a_reg == `LTLS_R_SEL) begin
        if (a_fld == `LTLS_S_EN)
          sel_en[a_sel] <= reg_wdata[0];
        else if (a_fld >= `LTLS_S_TBL && a_fld < `LTLS_S_CMB)
          ctn[s_ix] <= reg_wdata[2:0];
        else if (a_fld >= `LTLS_S_CMB && a_fld < `LTLS_S_CMB + 6'h03)
          cmb[m_ix] <= reg_wdata[2:0];
        else if (a_fld >= `LTLS_S_CND && a_fld <= `LTLS_S_CND_END) begin
          if (f_cnd[0])
            cop[c_ix] <= reg_wdata[2:0];
          else
            cnd[c_ix] <= reg_wdata;
        end
      end else if (reg_wr && a_reg == `LTLS_R_CONST)
        kval[reg_addr[`LTLS_A_CONST]] <= reg_wdata[15:0];
      for (i = 0; i < `LTLS_NTBL; i = i + 1)
        if (pr[pidx(i[2:0], 4'h0)] == `LTLS_AX_TIME)
          dec[i] <= 8'h00;
    end
  end

  // Read data stand only in the cycle after the strobe.
  always @(posedge clk) begin
    if (sys_rst || !reg_rd)
      reg_rdata <= 32'h00000000;
    else if (in_tbl && a_kind == `LTLS_K_PR)
      reg_rdata <= {24'h000000, pr[a_ix]};
    else if (in_tbl && a_kind == `LTLS_K_X)
      reg_rdata <= xc[a_ix];
    else if (in_tbl && a_kind == `LTLS_K_Y)
      reg_rdata <= {{16{yc[a_ix][15]}}, yc[a_ix]};
    else if (in_tbl && a_pt == `LTLS_ST_OUT)
      reg_rdata <= {{16{tbl_out_value[a_tbl*16+15]}},
                    tbl_out_value[a_tbl*16 +: 16]};
    else if (in_tbl && a_pt == `LTLS_ST_DEC)
      reg_rdata <= {24'h000000, dec[a_tbl]};
    else if (in_tbl && a_pt == `LTLS_ST_MS)
      reg_rdata <= ms_cnt[a_tbl];
    else if (a_reg == `LTLS_R_SEL && a_fld == `LTLS_S_EN)
      reg_rdata <= {31'h00000000, sel_en[a_sel]};
    else if (a_reg == `LTLS_R_SEL && a_fld >= `LTLS_S_TBL
             && a_fld < `LTLS_S_CMB)
      reg_rdata <= {29'h00000000, ctn[s_ix]};
    else if (a_reg == `LTLS_R_SEL && a_fld >= `LTLS_S_CMB
             && a_fld < `LTLS_S_CMB + 6'h03)
      reg_rdata <= {29'h00000000, cmb[m_ix]};
    else if (a_reg == `LTLS_R_SEL && a_fld >= `LTLS_S_CND
             && a_fld <= `LTLS_S_CND_END)
      reg_rdata <= f_cnd[0] ? {29'h00000000, cop[c_ix]} : cnd[c_ix];
    else if (a_reg == `LTLS_R_SEL && a_fld == `LTLS_S_ACT)
      reg_rdata <= {29'h00000000, sel_active_table[a_sel*3 +: 3]};
    else if (a_reg == `LTLS_R_SEL && a_fld == `LTLS_S_OUT)
      reg_rdata <= {{16{sel_out_value[a_sel*16+15]}},
                    sel_out_value[a_sel*16 +: 16]};
    else if (a_reg == `LTLS_R_CONST)
      reg_rdata <= {16'h0000, kval[reg_addr[`LTLS_A_CONST]]};
    else
      reg_rdata <= 32'h00000000;
  end

  // ----------------------------------------------------------------
  // Millisecond time base
  // ----------------------------------------------------------------
  // Elapsed time saturates rather than wrapping back to the start.
  always @(posedge clk) begin
    if (sys_rst) begin
      tick_cnt <= 16'h0000;
      ms_tick  <= 1'b0;
      for (j = 0; j < `LTLS_NTBL; j = j + 1)
        ms_cnt[j] <= 32'h00000000;
    end else begin
      ms_tick  <= (tick_cnt == MS_CYCLES - 1);
      tick_cnt <= (tick_cnt == MS_CYCLES - 1) ? 16'h0000
                                               : tick_cnt + 16'h0001;
      for (j = 0; j < `LTLS_NTBL; j = j + 1)
        if (!tbl_in_on[j] || pr[pidx(j[2:0], 4'h0)] != `LTLS_AX_TIME)
          ms_cnt[j] <= 32'h00000000;
        else if (ms_tick && ms_cnt[j] != 32'hFFFFFFFF)
          ms_cnt[j] <= ms_cnt[j] + 32'h00000001;
    end
  end

  // ----------------------------------------------------------------
  // Segment search for the table being refreshed
  // ----------------------------------------------------------------
  reg  [2:0]  ct;
  reg         st_wait;
  reg         ramp_neg;
  reg  [15:0] ramp_y0;
  reg         tm, hit, need_div, neg;
  reg  [31:0] in_x, x0, x1;
  reg  [15:0] y0, y1, direct, mag;
  reg  [3:0]  nvalid, seg;
  reg  [16:0] dy;
  wire        div_done;
  wire [48:0] div_q;
  // The divider loads on the edge that captures y0, so the dividend and
  // divisor come from the same segment and the same input sample.
  wire        div_start = !st_wait && need_div;
  wire [48:0] div_num   = {17'h00000, in_x - x0} * {33'h000000000, mag};

  always @* begin
    tm       = (pr[pidx(ct, 4'h0)] == `LTLS_AX_TIME);
    in_x     = tm ? ms_cnt[ct] : {16'h0000, tbl_in_value[ct*16 +: 16]};
    nvalid   = 4'hB;
    seg      = 4'h0;
    hit      = 1'b0;
    need_div = 1'b0;
    for (c = 10; c >= 1; c = c - 1)
      if (pr[pidx(ct, c[3:0])] == `LTLS_PT_IGNORE)
        nvalid = c[3:0];
    for (c = 10; c >= 1; c = c - 1)
      if (c < nvalid && in_x <= xc[pidx(ct, c[3:0])]) begin
        seg = c[3:0];
        hit = 1'b1;
      end
    x0  = (tm || !hit) ? 32'h00000000 : xc[pidx(ct, seg - 4'h1)];
    y0  = (tm && seg == 4'h1) ? 16'h0000 : yc[pidx(ct, seg - 4'h1)];
    x1  = xc[pidx(ct, seg)];
    y1  = yc[pidx(ct, seg)];
    if (tm && seg != 4'h1)
      x0 = xc[pidx(ct, seg - 4'h1)];
    dy  = {y1[15], y1} - {y0[15], y0};
    neg = dy[16];
    mag = neg ? (~dy[15:0] + 16'h0001) : dy[15:0];
    if (tm && !tbl_in_on[ct])
      direct = 16'h0000;
    else if (!hit)
      direct = (tm && nvalid == 4'h1) ? 16'h0000
                                      : yc[pidx(ct, nvalid - 4'h1)];
    else if (in_x <= x0)
      direct = y0;
    else if (pr[pidx(ct, seg)] == `LTLS_PT_STEP || x1 == x0)
      direct = y1;
    else begin
      direct   = y0;
      need_div = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Table refresh, one table at a time
  // ----------------------------------------------------------------
  // interpolation divide
  ltls_div u_div (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .start    (div_start),
    .dividend (div_num),
    .divisor  (x1 - x0),
    .done     (div_done),
    .quotient (div_q)
  );

  always @(posedge clk) begin
    if (sys_rst) begin
      ct            <= 3'h0;
      st_wait       <= 1'b0;
      ramp_neg      <= 1'b0;
      ramp_y0       <= 16'h0000;
      tbl_out_value <= 96'h0;
    end else if (!st_wait) begin
      if (need_div) begin
        ramp_neg  <= neg;
        ramp_y0   <= y0;
        st_wait   <= 1'b1;
      end else begin
        tbl_out_value[ct*16 +: 16] <= direct;
        ct <= (ct == `LTLS_LAST_TBL) ? 3'h0 : ct + 3'h1;
      end
    end else if (div_done) begin
      tbl_out_value[ct*16 +: 16] <= ramp_neg ? ramp_y0 - div_q[15:0]
                                             : ramp_y0 + div_q[15:0];
      st_wait <= 1'b0;
      ct      <= (ct == `LTLS_LAST_TBL) ? 3'h0 : ct + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Logic selectors
  // ----------------------------------------------------------------
  reg [1:0] pick [0:1];
  reg       found;
  reg [4:0] b;

  always @* begin
    for (sn = 0; sn < `LTLS_NSEL; sn = sn + 1) begin
      pick[sn] = 2'h0;  // fallback to A
      found    = 1'b0;
      for (cn = 0; cn < `LTLS_NCAND; cn = cn + 1) begin
        b = sn[4:0] * 5'h09 + cn[4:0] * 5'h03;
        if (!found && cmb_met(cond_eval(cnd[b], cop[b]),
                              cond_eval(cnd[b + 1], cop[b + 1]),
                              cond_eval(cnd[b + 2], cop[b + 2]),
                              cmb[sn * 3 + cn])) begin
          pick[sn] = cn[1:0];
          found    = 1'b1;
        end
      end
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      sel_out_value    <= 32'h00000000;
      sel_active_table <= 6'h00;
      sel_out_avail    <= 2'h0;
    end else begin
      for (s = 0; s < `LTLS_NSEL; s = s + 1) begin
        if (!sel_en[s]) begin
          sel_out_value[s*16 +: 16]   <= 16'h0000;
          sel_active_table[s*3 +: 3]  <= 3'h0;
          sel_out_avail[s]            <= 1'b0;
        end else begin
          sel_active_table[s*3 +: 3] <= ctn[s * 3 + pick[s]];
          if (ctn[s * 3 + pick[s]] == 3'h0
              || ctn[s * 3 + pick[s]] > 3'h6) begin
            sel_out_value[s*16 +: 16] <= 16'h0000;
            sel_out_avail[s]          <= 1'b0;
            // An unusable table number reads back as none selected.
            sel_active_table[s*3 +: 3] <= 3'h0;
          end else begin
            sel_out_value[s*16 +: 16] <=
              tbl_out_value[(ctn[s * 3 + pick[s]] - 3'h1)*16 +: 16];
            sel_out_avail[s] <= 1'b1;
          end
        end
      end
    end
  end

endmodule // ltls_top

//--- verif/ltls_pool.sv
// Model of the blocks feeding the selectors.
// Assumes the bench sets entry 0 and its error flag.
`timescale 1ns/10ps
module ltls_pool (
  input  logic [15:0]  v0,         // Entry 0 value.
  input  logic         e0,         // Entry 0 error.
  output logic [255:0] pool_value, // All entries.
  output logic [15:0]  pool_error, // Error flags.
  output logic [15:0]  pool_avail  // Availability.
);
  // Only entry 0 is live, so stray sources read as unavailable.
  assign pool_value = {240'h0, v0};
  assign pool_error = {15'h0, e0};
  assign pool_avail = 16'h0001;
endmodule // ltls_pool

//--- verif/ltls_monitor.sv
// Port checker for the table and selector block.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/10ps
module ltls_monitor (
  input logic        clk,              // Clock.
  input logic        sys_rst,          // Reset.
  input logic        reg_rd,           // Read strobe.
  input logic [31:0] reg_rdata,        // Read data.
  input logic [95:0] tbl_out_value,    // Table outputs.
  input logic [31:0] sel_out_value,    // Selector outputs.
  input logic [5:0]  sel_active_table, // Selected tables.
  input logic [1:0]  sel_out_avail     // Output valid.
);
  // ------------------------------------------------
  // Port relations
  // ------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_sel0_range: assert property (sel_active_table[2:0] <= 3'h6)
    else $error("sel0 table out of range");
  a_sel1_range: assert property (sel_active_table[5:3] <= 3'h6)
    else $error("sel1 table out of range");
  a_sel0_off: assert property (sel_active_table[2:0] == 3'h0 |->
    !sel_out_avail[0] && sel_out_value[15:0] == 16'h0)
    else $error("sel0 idle output not cleared");
  a_sel1_off: assert property (sel_active_table[5:3] == 3'h0 |->
    !sel_out_avail[1] && sel_out_value[31:16] == 16'h0)
    else $error("sel1 idle output not cleared");
  a_sel0_follow: assert property (sel_out_avail[0] |->
    sel_out_value[15:0] == 16'($past(tbl_out_value) >>
    (16 * (sel_active_table[2:0] - 3'h1)))) else $error("sel0 value");
  a_sel1_follow: assert property (sel_out_avail[1] |->
    sel_out_value[31:16] == 16'($past(tbl_out_value) >>
    (16 * (sel_active_table[5:3] - 3'h1)))) else $error("sel1 value");
  a_reset_off: assert property ($fell(sys_rst) |->
    sel_out_avail == 2'h0 && sel_active_table == 6'h00)
    else $error("selector live after reset");
  a_rdata_pulse: assert property (!$past(reg_rd) |->
    reg_rdata == 32'h0) else $error("read data outside its slot");
  c_sel0_live: cover property (sel_out_avail[0]);
  c_sel0_b: cover property (sel_active_table[2:0] == 3'h2);
  c_sel0_c: cover property (sel_active_table[2:0] == 3'h3);
endmodule // ltls_monitor
bind ltls_top ltls_monitor i_mon (.clk, .sys_rst, .reg_rd, .reg_rdata,
  .tbl_out_value, .sel_out_value, .sel_active_table, .sel_out_avail);

//--- verif/ltls_top_tb.sv
// Bench for the lookup table and selector block.
// Assumes the register port answers reads one cycle late.
`timescale 1ns/10ps
module ltls_top_tb;
  logic clk, sys_rst, reg_wr, reg_rd, e0;
  logic [9:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, sel_out_value;
  logic [95:0] tbl_in_value, tbl_out_value;
  logic [5:0] tbl_in_on, sel_active_table;
  logic [255:0] pool_value;
  logic [15:0] pool_error, pool_avail, v0;
  logic [1:0] sel_out_avail;
  int err_total = 0, checks = 0;
  ltls_top #(.MS_CYCLES(10)) i_dut (.clk, .sys_rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .tbl_in_value, .tbl_in_on, .pool_value,
    .pool_error, .pool_avail, .tbl_out_value, .sel_out_value,
    .sel_active_table, .sel_out_avail);
  ltls_pool i_pool (.v0, .e0, .pool_value, .pool_error, .pool_avail);
  // Free-running 50 MHz clock.
  always #10 clk = ~clk;
  // ------------------------------------------------
  // Tasks
  // ------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk("reg_rdata", e, reg_rdata);
  endtask
  // Tables refresh in turn, so wait a bounded time for the value.
  task automatic wv(input bit s, input logic [15:0] e);
    logic [15:0] g;
    for (int i = 0; i < 1000; i++) begin
      @(negedge clk);
      g = s ? {13'h0, sel_active_table[2:0]} : tbl_out_value[15:0];
      if (g === e) break;
    end
    chk(s ? "sel_active" : "tbl_out", {16'h0, e}, {16'h0, g});
    // A wait that runs out ends the run at once.
    if (g !== e) complete_run();
  endtask
  task automatic complete_run();
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence; input 35 sits inside segment 3 to 4 of table 0.
  initial begin
    {clk, reg_wr, reg_rd, e0, reg_addr, reg_wdata, tbl_in_on} = 0;
    sys_rst = 1'b1;
    v0 = 16'h3;
    tbl_in_value = {80'h0, 16'h23};
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    for (int p = 0; p < 11; p++) begin
      rd({3'h5, 2'h1, 4'(p)}, 32'(10 * p));
      rd({3'h5, 2'h2, 4'(p)}, 32'(10 * p));
      rd({3'h5, 2'h0, 4'(p)}, p ? 32'h1 : 32'h0);
    end
    rd(10'h200, 32'h0);
    rd(10'h210, 32'h0);
    rd(10'h211, 32'h0);
    rd(10'h203, 32'h3);
    wv(0, 16'h23);
    wr(10'h024, 32'h3C);
    wv(0, 16'h2D);
    wr(10'h004, 32'h2);
    wv(0, 16'h3C);
    wr(10'h004, 32'h0);
    wv(0, 16'h1E);
    wr(10'h040, 32'h2);
    rd(10'h040, 32'h0);
    wr(10'h200, 32'h1);
    wv(1, 16'h1);
    wr(10'h300, 32'h5);
    wr(10'h210, 32'h00020001);
    wr(10'h211, 32'h2);
    wr(10'h204, 32'h2);
    wv(1, 16'h2);
    @(posedge clk);
    v0 <= 16'hA;
    wv(1, 16'h1);
    chk("sel_out", 32'h1E, {16'h0, sel_out_value[15:0]});
    chk("sel_avail", 32'h1, {31'h0, sel_out_avail[0]});
    @(posedge clk);
    e0 <= 1'b1;
    wv(1, 16'h2);
    wr(10'h205, 32'h2);
    wr(10'h206, 32'h2);
    wv(1, 16'h1);
    wr(10'h206, 32'h0);
    wv(1, 16'h3);
    wr(10'h200, 32'h0);
    wv(1, 16'h0);
    // Time axis on table 1: decimals, clamps, then output on and off.
    wr(10'h071, 32'h3);
    rd(10'h071, 32'h3);
    wr(10'h040, 32'h1);
    rd(10'h071, 32'h0);
    wr(10'h051, 32'h0);
    rd(10'h051, 32'h1);
    wr(10'h052, 32'h06000000);
    rd(10'h052, 32'h05265C00);
    wr(10'h050, 32'h5);
    rd(10'h050, 32'h0);
    @(posedge clk);
    tbl_in_on <= 6'h02;
    repeat (400) @(posedge clk);
    rd(10'h070, 32'hA);
    @(posedge clk);
    tbl_in_on <= 6'h00;
    repeat (400) @(posedge clk);
    rd(10'h070, 32'h0);
    rd(10'h072, 32'h0);
    complete_run();
  end
endmodule // ltls_top_tb
